// [src/apc_pkg.sv]
// Package of constants, types and functions for the converter control block
// Operation
// RULE_01: Control register write aborts sequence, never starts
// RULE_02: Power bit 7: 0 down, 1 normal
// RULE_03: Software waits recovery time after power-up
// RULE_04: Normal clear: status read, then result read
// RULE_05: Fast clear: any result access clears flag
// RULE_06: Bit 5 halts and powers down in wait
// RULE_07: Wait exit resumes halted conversion; discard result
// RULE_08: Bit 4: 0 edge, 1 level trigger
// RULE_09: Bit 3: 0 falling/low, 1 rising/high
// RULE_10: Bit 2 enables external trigger starts
// RULE_11: Analog trigger source enables its digital buffer
// RULE_12: Bit 1 gates sequence-done interrupt request
// RULE_13: Bit 0 reads done flag when enabled; read-only
// RULE_14: Source kind bit plus four-bit channel field
// RULE_15: All writable fields reset to zero
package apc_pkg;

   // ***************************************************************
   // Register map (byte addresses)
   // ***************************************************************
   localparam logic [7:0] OFF_CTRL2 = 8'h00;
   localparam logic [7:0] OFF_TRIGSEL = 8'h04;
   localparam logic [7:0] OFF_SEQ = 8'h08;
   localparam logic [7:0] OFF_CHSTAT = 8'h0C;
   localparam logic [7:0] OFF_RES_BASE = 8'h40;
   localparam logic [7:0] OFF_RES_LAST = 8'h7C;

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int BIT_POWER = 7;
   localparam int BIT_FFC = 6;
   localparam int BIT_WAITPD = 5;
   localparam int BIT_LEVEL = 4;
   localparam int BIT_POL = 3;
   localparam int BIT_EXTEN = 2;
   localparam int BIT_IRQEN = 1;
   localparam int BIT_IRQFLAG = 0;
   localparam int BIT_KIND = 7;
   localparam int BIT_SEQ_START = 0;
   localparam int BIT_SEQ_SCF = 1;
   localparam int BIT_SEQ_BUSY = 2;
   localparam int BIT_SEQ_HALT = 3;

   // ***************************************************************
   // Sizes and reset values
   // ***************************************************************
   localparam int NUM_CH = 16;
   localparam int NUM_TRIG = 4;
   localparam int RES_W = 10;
   localparam logic [3:0] SEQ_LAST = 4'h3;
   localparam logic [7:0] CTRL2_RESET = 8'h00;
   localparam logic [4:0] TRIGSEL_RESET = 5'h00;

   // Writable control fields, bit 0 of the register is read-only
   typedef struct packed {
      logic power;
      logic ffc;
      logic waitpd;
      logic level;
      logic pol;
      logic exten;
      logic irqen;
   } apc_ctrl_t;

   // Trigger source selection
   typedef struct packed {
      logic kind;
      logic [3:0] chan;
   } apc_trigsel_t;

   // Sequencer states, one-hot
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RUN = 3'b010,
      ST_HALT = 3'b100
   } apc_state_t;

   // Address falls in the result window
   function automatic logic is_result(input logic [7:0] addr);
      is_result = (addr >= OFF_RES_BASE) && (addr <= OFF_RES_LAST)
                  && (addr[1:0] == 2'b00);
   endfunction : is_result

   // Result slot index from address
   function automatic logic [3:0] res_index(input logic [7:0] addr);
      res_index = addr[5:2];
   endfunction : res_index

endpackage : apc_pkg

// [src/apc_result_mem.sv]
// Result storage, sixteen words with registered read data
`timescale 1ns/1ps
module apc_result_mem
   import apc_pkg::*;
(
   // Clock
   input wire logic clk_in,
   // Write port
   input wire logic wr_en_in,
   input wire logic [3:0] wr_addr_in,
   input wire logic [RES_W-1:0] wr_data_in,
   // Read port
   input wire logic [3:0] rd_addr_in,
   output logic [RES_W-1:0] rd_data_out
);

   logic [RES_W-1:0] mem_q [NUM_CH];

   // Storage has no reset; flags tell software what is valid
   always_ff @(posedge clk_in) begin
      if (wr_en_in) begin
         mem_q[wr_addr_in] <= wr_data_in;
      end
      rd_data_out <= mem_q[rd_addr_in];
   end

endmodule : apc_result_mem

// [src/apc_trig_detect.sv]
// External trigger edge and level detector
`timescale 1ns/1ps
module apc_trig_detect
   import apc_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Configuration
   input wire logic enable_in,
   input wire logic level_in,
   input wire logic pol_in,
   // Trigger source and result
   input wire logic src_in,
   output logic fire_out
);

   logic prev_q;
   logic prev_d;
   logic fire_q;
   logic fire_d;

   // Edge or level qualification
   always_comb begin
      prev_d = src_in;
      fire_d = 1'b0;
      if (enable_in) begin
         if (level_in) begin
            fire_d = (src_in == pol_in);                 // [RULE_08] [RULE_09]
         end else if (pol_in) begin
            fire_d = src_in & ~prev_q;                   // [RULE_09]
         end else begin
            fire_d = ~src_in & prev_q;                   // [RULE_09]
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         prev_q <= 1'b0;
         fire_q <= 1'b0;
      end else begin
         prev_q <= prev_d;
         fire_q <= fire_d;
      end
   end

   assign fire_out = fire_q;

endmodule : apc_trig_detect

// [src/apc_top.sv]
// Converter control register, trigger, flags and sequencer
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
module apc_top
   import apc_pkg::*;
(
   // Clock and reset
   input wire logic CLK_SYS_IN,
   input wire logic SYS_RST_IN,
   // APB slave
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [7:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   output logic [31:0] PRDATA_OUT,
   output logic PREADY_OUT,
   output logic PSLVERR_OUT,
   // Device mode
   input wire logic WAIT_MODE_IN,
   // Trigger sources
   input wire logic [NUM_CH-1:0] ANALOG_DIG_IN,
   input wire logic [NUM_TRIG-1:0] TRIG_IN,
   output logic [NUM_CH-1:0] DIG_BUF_EN_OUT,
   // Analog converter core
   output logic ANALOG_POWER_OUT,
   output logic CONV_START_OUT,
   output logic [3:0] CONV_CHAN_OUT,
   output logic CONV_ABORT_OUT,
   input wire logic CONV_DONE_IN,
   input wire logic [RES_W-1:0] CONV_DATA_IN,
   // Interrupt request
   output logic SEQ_IRQ_OUT
);

   // ***************************************************************
   // Declarations
   // ***************************************************************
   apc_ctrl_t ctrl_q, ctrl_d;
   apc_trigsel_t tsel_q, tsel_d;
   apc_state_t state_q, state_d;
   logic [3:0] cnt_q, cnt_d;
   logic busy_conv_q, busy_conv_d;
   logic start_q, start_d;
   logic abort_q, abort_d;
   logic scf_q, scf_d;
   logic [NUM_CH-1:0] ccf_q, ccf_d;
   logic [NUM_CH-1:0] armed_q, armed_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   logic [31:0] prdata_q, prdata_d;
   logic power_q, power_d;
   logic irq_q, irq_d;
   logic [NUM_CH-1:0] bufen_q, bufen_d;
   logic commit;
   logic wr_ctrl2;
   logic sw_start;
   logic trig_src;
   logic trig_fire;
   logic abort_now;
   logic seq_begin;
   logic res_wr;
   logic [RES_W-1:0] res_rdata;
   logic [NUM_CH-1:0] res_hit;
   logic [NUM_CH-1:0] clr_ccf;
   logic [NUM_CH-1:0] set_ccf;
   logic [7:0] ctrl_byte;

   // ***************************************************************
   // APB decode
   // ***************************************************************
   // Access completes on the edge where our own ready is seen high
   assign commit = PSEL_IN & PENABLE_IN & pready_q;
   assign wr_ctrl2 = commit & PWRITE_IN & (PADDR_IN == OFF_CTRL2);
   assign sw_start = commit & PWRITE_IN & (PADDR_IN == OFF_SEQ)
                     & PWDATA_IN[BIT_SEQ_START];

   // Read view of the control register, bit 0 shows the done flag gated by bit 1
   assign ctrl_byte = {ctrl_q.power, ctrl_q.ffc, ctrl_q.waitpd,
                       ctrl_q.level, ctrl_q.pol, ctrl_q.exten,
                       ctrl_q.irqen, ctrl_q.irqen & scf_q}; // [RULE_13]

   // Ready after one wait state so the result memory can be read
   always_comb begin
      pready_d = PSEL_IN & PENABLE_IN & ~pready_q;
      pslverr_d = 1'b0;
      prdata_d = prdata_q;
      if (pready_d) begin
         prdata_d = 32'h0000_0000;
         case (PADDR_IN)
            OFF_CTRL2: prdata_d = {24'h00_0000, ctrl_byte};
            OFF_TRIGSEL: prdata_d = {24'h00_0000, tsel_q.kind, 3'h0,
                                     tsel_q.chan};
            OFF_SEQ: prdata_d = {28'h000_0000, state_q == ST_HALT,
                                 state_q != ST_IDLE, scf_q, 1'b0};
            OFF_CHSTAT: prdata_d = {16'h0000, ccf_q};
            default: begin
               if (is_result(PADDR_IN)) begin
                  prdata_d = {22'h00_0000, res_rdata};
               end else begin
                  pslverr_d = 1'b1;
               end
            end
         endcase
         if (PWRITE_IN) begin
            prdata_d = 32'h0000_0000;
         end
      end
   end

   // ***************************************************************
   // Configuration registers
   // ***************************************************************
   // Bit 0 is not stored, so writes to it have no effect
   always_comb begin
      ctrl_d = ctrl_q;
      tsel_d = tsel_q;
      if (wr_ctrl2) begin
         ctrl_d = PWDATA_IN[7:1];                  // [RULE_02] [RULE_13]
      end
      if (commit & PWRITE_IN & (PADDR_IN == OFF_TRIGSEL)) begin
         tsel_d.kind = PWDATA_IN[BIT_KIND];        // [RULE_14]
         tsel_d.chan = PWDATA_IN[3:0];             // [RULE_14]
      end
   end

   // ***************************************************************
   // Trigger source selection
   // ***************************************************************
   // Reserved dedicated codes select a constant low source, which fires in low-level mode
   always_comb begin
      trig_src = 1'b0;
      bufen_d = '0;
      if (!tsel_q.kind) begin
         trig_src = ANALOG_DIG_IN[tsel_q.chan];    // [RULE_14]
         if (ctrl_q.exten) begin
            bufen_d[tsel_q.chan] = 1'b1;           // [RULE_11]
         end
      end else if (tsel_q.chan < 4'(NUM_TRIG)) begin
         trig_src = TRIG_IN[tsel_q.chan[1:0]];     // [RULE_14]
      end
   end

   apc_trig_detect u_trig (
      .clk_in(CLK_SYS_IN),
      .rst_in(SYS_RST_IN),
      .enable_in(ctrl_q.exten),                    // [RULE_10]
      .level_in(ctrl_q.level),
      .pol_in(ctrl_q.pol),
      .src_in(trig_src),
      .fire_out(trig_fire)
   );

   // ***************************************************************
   // Conversion sequencer
   // ***************************************************************
   // A powered-down converter cannot hold a sequence either
   assign abort_now = wr_ctrl2 | ~ctrl_q.power;    // [RULE_01] [RULE_02]
   assign seq_begin = (state_q == ST_IDLE) & ~abort_now
                      & (sw_start | (trig_fire & ctrl_q.exten)); // [RULE_10]
   assign res_wr = (state_q == ST_RUN) & busy_conv_q & CONV_DONE_IN
                   & ~abort_now;

   // Control register write only aborts; a start needs its own cause
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      busy_conv_d = busy_conv_q;
      start_d = 1'b0;
      abort_d = 1'b0;
      case (state_q)
         ST_IDLE: begin
            if (seq_begin) begin
               state_d = ST_RUN;
               cnt_d = 4'h0;
               start_d = 1'b1;
               busy_conv_d = 1'b1;
            end
         end
         ST_RUN: begin
            if (abort_now) begin
               state_d = ST_IDLE;                  // [RULE_01]
               busy_conv_d = 1'b0;
               abort_d = 1'b1;
            end else if (WAIT_MODE_IN & ctrl_q.waitpd) begin
               state_d = ST_HALT;                  // [RULE_06]
               busy_conv_d = 1'b0;
               abort_d = 1'b1;
            end else if (res_wr) begin
               busy_conv_d = 1'b0;
               if (cnt_q == SEQ_LAST) begin
                  state_d = ST_IDLE;
               end else begin
                  cnt_d = cnt_q + 4'h1;
                  start_d = 1'b1;
                  busy_conv_d = 1'b1;
               end
            end
         end
         ST_HALT: begin
            if (abort_now) begin
               state_d = ST_IDLE;                  // [RULE_01]
            end else if (!WAIT_MODE_IN) begin
               // Reissue the slot that was cut; its value is unreliable
               state_d = ST_RUN;                   // [RULE_07]
               start_d = 1'b1;
               busy_conv_d = 1'b1;
            end
         end
         default: begin
            state_d = ST_IDLE;
            busy_conv_d = 1'b0;
         end
      endcase
   end

   // Converter power follows the power bit, gated by wait power-down
   always_comb begin
      power_d = ctrl_q.power & ~(WAIT_MODE_IN & ctrl_q.waitpd); // [RULE_06]
      irq_d = ctrl_q.irqen & scf_q;                // [RULE_12]
   end

   // ***************************************************************
   // Completion flags
   // ***************************************************************
   // Per-slot access decode, shared by both clearing modes
   always_comb begin
      res_hit = '0;
      if (commit & is_result(PADDR_IN)) begin
         res_hit[res_index(PADDR_IN)] = 1'b1;
      end
   end

   // Set wins over clear, so no completion is lost
   always_comb begin
      set_ccf = '0;
      if (res_wr) begin
         set_ccf[cnt_q] = 1'b1;
      end
      if (ctrl_q.ffc) begin
         clr_ccf = res_hit;                        // [RULE_05]
      end else begin
         clr_ccf = res_hit & armed_q & {NUM_CH{~PWRITE_IN}}; // [RULE_04]
      end
      ccf_d = (ccf_q & ~clr_ccf) | set_ccf;
      armed_d = armed_q & ~clr_ccf & ~set_ccf;
      if (commit & ~PWRITE_IN & (PADDR_IN == OFF_CHSTAT)) begin
         armed_d = ccf_q & ~set_ccf;               // [RULE_04]
      end
      scf_d = scf_q;
      if (seq_begin) begin
         scf_d = 1'b0;
      end
      if (commit & PWRITE_IN & (PADDR_IN == OFF_SEQ)
          & PWDATA_IN[BIT_SEQ_SCF]) begin
         scf_d = 1'b0;
      end
      if (res_wr & (cnt_q == SEQ_LAST)) begin
         scf_d = 1'b1;
      end
   end

   apc_result_mem u_mem (
      .clk_in(CLK_SYS_IN),
      .wr_en_in(res_wr),
      .wr_addr_in(cnt_q),
      .wr_data_in(CONV_DATA_IN),
      .rd_addr_in(res_index(PADDR_IN)),
      .rd_data_out(res_rdata)
   );

   // ***************************************************************
   // State registers
   // ***************************************************************
   always_ff @(posedge CLK_SYS_IN) begin
      if (SYS_RST_IN) begin
         ctrl_q <= apc_ctrl_t'(CTRL2_RESET[7:1]);  // [RULE_15]
         tsel_q <= apc_trigsel_t'(TRIGSEL_RESET);
         state_q <= ST_IDLE;
         cnt_q <= 4'h0;
         busy_conv_q <= 1'b0;
         start_q <= 1'b0;
         abort_q <= 1'b0;
         scf_q <= 1'b0;
         ccf_q <= '0;
         armed_q <= '0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         power_q <= 1'b0;
         irq_q <= 1'b0;
         bufen_q <= '0;
      end else begin
         ctrl_q <= ctrl_d;
         tsel_q <= tsel_d;
         state_q <= state_d;
         cnt_q <= cnt_d;
         busy_conv_q <= busy_conv_d;
         start_q <= start_d;
         abort_q <= abort_d;
         scf_q <= scf_d;
         ccf_q <= ccf_d;
         armed_q <= armed_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q <= prdata_d;
         power_q <= power_d;
         irq_q <= irq_d;
         bufen_q <= bufen_d;
      end
   end

   // ***************************************************************
   // Outputs, all straight from flip-flops
   // ***************************************************************
   assign PRDATA_OUT = prdata_q;
   assign PREADY_OUT = pready_q;
   assign PSLVERR_OUT = pslverr_q;
   assign DIG_BUF_EN_OUT = bufen_q;
   assign ANALOG_POWER_OUT = power_q;
   assign CONV_START_OUT = start_q;
   assign CONV_CHAN_OUT = cnt_q;
   assign CONV_ABORT_OUT = abort_q;
   assign SEQ_IRQ_OUT = irq_q;

endmodule : apc_top

// [test/apc_checker.sv]
// Port-level assertions for the converter control block
`timescale 1ns/1ps
module apc_checker
   import apc_pkg::*;
(
   // Clock and reset
   input wire logic CLK_SYS_IN,
   input wire logic SYS_RST_IN,
   // Register bus
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [7:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   input wire logic [31:0] PRDATA_OUT,
   input wire logic PREADY_OUT,
   input wire logic PSLVERR_OUT,
   // Converter side
   input wire logic WAIT_MODE_IN,
   input wire logic [NUM_CH-1:0] DIG_BUF_EN_OUT,
   input wire logic ANALOG_POWER_OUT,
   input wire logic CONV_START_OUT,
   input wire logic SEQ_IRQ_OUT
);
   // ***************************************************************
   // Shadow of the writable fields, seen from committed writes
   // ***************************************************************
   logic [6:0] ctl_q, ctl_d;
   logic [4:0] sel_q, sel_d;
   logic commit, unmapped, pwr_exp;
   logic [NUM_CH-1:0] buf_exp;

   // Commit edge and derived expectations
   assign commit = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN;
   assign unmapped = !(PADDR_IN[1:0] == 2'b00 && (PADDR_IN <= OFF_CHSTAT
      || (PADDR_IN >= OFF_RES_BASE && PADDR_IN <= OFF_RES_LAST)));
   assign pwr_exp = ctl_q[6] && !(WAIT_MODE_IN && ctl_q[4]);
   assign buf_exp = (ctl_q[1] && !sel_q[4]) ? 16'h0001 << sel_q[3:0]
                                            : 16'h0000;

   // Next shadow values, bit 0 of control never stored
   always_comb begin
      ctl_d = ctl_q;
      sel_d = sel_q;
      if (commit && PADDR_IN == OFF_CTRL2) ctl_d = PWDATA_IN[7:1];
      if (commit && PADDR_IN == OFF_TRIGSEL)
         sel_d = {PWDATA_IN[7], PWDATA_IN[3:0]};
   end

   // Shadow registers
   always_ff @(posedge CLK_SYS_IN) begin
      if (SYS_RST_IN) begin
         ctl_q <= 7'h00;
         sel_q <= 5'h00;
      end else begin
         ctl_q <= ctl_d;
         sel_q <= sel_d;
      end
   end

   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge CLK_SYS_IN); endclocking
   default disable iff (SYS_RST_IN);

   a_power_follows: assert property (ANALOG_POWER_OUT == $past(pwr_exp))
      else $error("converter power output wrong");
   a_write_no_start: assert property (commit && PADDR_IN == OFF_CTRL2
      |=> !CONV_START_OUT) else $error("control write started a sequence");
   a_start_powered: assert property (CONV_START_OUT |-> $past(ctl_q[6]))
      else $error("start while powered down");
   a_irq_gated: assert property (SEQ_IRQ_OUT |-> $past(ctl_q[0]))
      else $error("interrupt request while disabled");
   a_ctrl_readback: assert property (PREADY_OUT && !PWRITE_IN
      && PADDR_IN == OFF_CTRL2 |-> PRDATA_OUT == {24'h0, ctl_q, SEQ_IRQ_OUT})
      else $error("control read value wrong");
   a_buf_follows: assert property (DIG_BUF_EN_OUT == $past(buf_exp))
      else $error("digital buffer enable wrong");
   a_ready_wait: assert property (PSEL_IN && PENABLE_IN && !PREADY_OUT
      |=> PREADY_OUT) else $error("ready not after one wait");
   a_slverr_map: assert property (PREADY_OUT |-> PSLVERR_OUT == unmapped)
      else $error("error response wrong");

endmodule : apc_checker

bind apc_top apc_checker u_chk (.CLK_SYS_IN, .SYS_RST_IN, .PSEL_IN,
   .PENABLE_IN, .PWRITE_IN, .PADDR_IN, .PWDATA_IN, .PRDATA_OUT, .PREADY_OUT,
   .PSLVERR_OUT, .WAIT_MODE_IN, .DIG_BUF_EN_OUT, .ANALOG_POWER_OUT,
   .CONV_START_OUT, .SEQ_IRQ_OUT);

// [test/apc_top_test.sv]
// Self-checking testbench for the converter control block
`timescale 1ns/1ps
module apc_top_test
   import apc_pkg::*;
;
   // ***************************************************************
   // Signals
   // ***************************************************************
   logic clk, rst, psel, pen, pwr, wmode, done, prdy, perr;
   logic apower, start, abort_p, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [NUM_CH-1:0] adig, buf_en;
   logic [NUM_TRIG-1:0] trig;
   logic [3:0] chan;
   logic [RES_W-1:0] cdata;
   int errors, checks_done, n_start, n_abort;
   // Settling allowance after power-up, the figure is our own choice
   localparam int RECOVER_CYC = 4;

   apc_top dut (.CLK_SYS_IN(clk), .SYS_RST_IN(rst), .PSEL_IN(psel),
      .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
      .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(prdy),
      .PSLVERR_OUT(perr), .WAIT_MODE_IN(wmode), .ANALOG_DIG_IN(adig),
      .TRIG_IN(trig), .DIG_BUF_EN_OUT(buf_en), .ANALOG_POWER_OUT(apower),
      .CONV_START_OUT(start), .CONV_CHAN_OUT(chan), .CONV_ABORT_OUT(abort_p),
      .CONV_DONE_IN(done), .CONV_DATA_IN(cdata), .SEQ_IRQ_OUT(irq));

   // Free-running clock
   always #5 clk = ~clk;

   // Pulse counters, sampled before each edge updates them
   always @(posedge clk) begin
      if (start === 1'b1) n_start++;
      if (abort_p === 1'b1) n_abort++;
   end

   // ***************************************************************
   // Shared tasks
   // ***************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask : check

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : final_report

   // Settle point for sampling outputs
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc

   // One bus transfer; held until ready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      // Ready, read data and error are all taken at the same rising edge
      do begin
         @(posedge clk);
         n++;
      end while (prdy !== 1'b1 && n < 20);
      if (n >= 20) check(1'b0, 1'b1);
      r = prdata;
      e = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      logic e;
      apb(1'b0, a, 32'h0, r, e);
   endtask : rd

   task automatic wait_start(output logic g);
      g = 1'b0;
      for (int n = 0; n < 20 && !g; n++) begin
         @(negedge clk);
         g = (start === 1'b1);
      end
   endtask : wait_start

   // Converter core answering all four slots, result 0x100 plus slot
   task automatic run_slots();
      logic g;
      for (int i = 0; i < 4; i++) begin
         wait_start(g);
         check(g, 1'b1);
         check(chan, i);
         @(posedge clk);
         done <= 1'b1;
         cdata <= 10'h100 + i[9:0];
         @(posedge clk);
         done <= 1'b0;
      end
   endtask : run_slots

   // ***************************************************************
   // Scenarios
   // ***************************************************************
   task automatic t_regs();
      logic [31:0] r;
      logic e;
      rd(OFF_CTRL2, r);
      check(r, 32'h0);
      wr(OFF_CTRL2, 32'hFF);
      rd(OFF_CTRL2, r);
      check(r, 32'hFE);
      check(apower, 1'b1);
      check(buf_en, 16'h0001);
      wr(OFF_TRIGSEL, 32'h85);
      cyc(2);
      check(buf_en, 16'h0000);
      wr(OFF_TRIGSEL, 32'h05);
      cyc(2);
      check(buf_en, 16'h0020);
      apb(1'b1, 8'h20, 32'hFF, r, e);
      check(e, 1'b1);
      wr(OFF_CTRL2, 32'h00);
      cyc(2);
      check(apower, 1'b0);
      $display("register test done");
   endtask : t_regs

   task automatic t_seq();
      logic [31:0] r;
      wr(OFF_CTRL2, 32'h82);
      cyc(RECOVER_CYC); // Analog side settles after power-up
      wr(OFF_SEQ, 32'h1);
      run_slots();
      cyc(3);
      check(irq, 1'b1);
      rd(OFF_CTRL2, r);
      check(r, 32'h83);
      rd(OFF_RES_BASE, r);
      check(r, 32'h100);
      rd(OFF_CHSTAT, r);
      check(r, 32'hF);
      rd(OFF_RES_BASE, r);
      rd(OFF_CHSTAT, r);
      check(r, 32'hE);
      wr(OFF_CTRL2, 32'hC2);
      rd(8'h44, r);
      check(r, 32'h101);
      rd(OFF_CHSTAT, r);
      check(r, 32'hC);
      wr(OFF_CTRL2, 32'hC0);
      cyc(2);
      check(irq, 1'b0);
      rd(OFF_CTRL2, r);
      check(r, 32'hC0);
      $display("sequence test done");
   endtask : t_seq

   task automatic t_abort();
      logic [31:0] r;
      logic g;
      int a0, s0;
      wr(OFF_CTRL2, 32'h80);
      wr(OFF_SEQ, 32'h1);
      wait_start(g);
      // Let the counter take this start pulse before the baseline
      cyc(1);
      a0 = n_abort;
      s0 = n_start;
      wr(OFF_CTRL2, 32'h80);
      cyc(10);
      check(n_abort - a0, 1);
      check(n_start - s0, 0);
      rd(OFF_SEQ, r);
      check(r[2], 1'b0);
      $display("abort test done");
   endtask : t_abort

   task automatic t_trig();
      int s0;
      for (int m = 0; m < 4; m++) begin
         @(posedge clk) trig <= {3'b000, ~m[0]};
         wr(OFF_TRIGSEL, 32'h80);
         wr(OFF_CTRL2, 32'h84 | (m << 3));
         s0 = n_start;
         cyc(6);
         check(n_start - s0, 0);
         @(posedge clk) trig[0] <= m[0];
         run_slots();
         s0 = n_start;
         cyc(8);
         check(n_start != s0, m[1]);
         @(posedge clk) trig[0] <= ~m[0];
         cyc(3);
         wr(OFF_CTRL2, 32'h80);
      end
      s0 = n_start;
      @(posedge clk) trig <= 4'hF;
      cyc(4);
      @(posedge clk) trig <= 4'h0;
      cyc(4);
      check(n_start - s0, 0);
      wr(OFF_TRIGSEL, 32'h03);
      wr(OFF_CTRL2, 32'h8C);
      cyc(2);
      check(buf_en, 16'h0008);
      @(posedge clk) adig[3] <= 1'b1;
      run_slots();
      wr(OFF_CTRL2, 32'h80);
      @(posedge clk) adig <= '0;
      $display("trigger test done");
   endtask : t_trig

   task automatic t_wait();
      logic [31:0] r;
      logic g;
      int a0;
      wr(OFF_CTRL2, 32'hA0);
      wr(OFF_SEQ, 32'h1);
      wait_start(g);
      @(posedge clk) wmode <= 1'b1;
      a0 = n_abort;
      cyc(4);
      check(apower, 1'b0);
      check(n_abort - a0, 1);
      rd(OFF_SEQ, r);
      check(r[3], 1'b1);
      @(posedge clk) wmode <= 1'b0;
      wait_start(g);
      check(g, 1'b1);
      check(chan, 4'h0);
      wr(OFF_CTRL2, 32'h80);
      @(posedge clk) wmode <= 1'b1;
      cyc(3);
      check(apower, 1'b1);
      @(posedge clk) wmode <= 1'b0;
      $display("wait test done");
   endtask : t_wait

   // ***************************************************************
   // Main sequence and watchdog
   // ***************************************************************
   initial begin
      {clk, psel, pen, pwr, wmode, done} = '0;
      {paddr, pwdata, adig, trig, cdata} = '0;
      rst = 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_seq();
      t_abort();
      t_trig();
      t_wait();
      final_report();
   end

   // Hang guard, far beyond the few hundred cycles needed
   initial begin
      #200000;
      errors++;
      final_report();
   end

endmodule : apc_top_test
